// ==== design/pwm_io_write_lock.sv ====
// pwm output/fault control registers behind a key-sequence write lock
// Summary of operation
// - lock enable from config word bit six
// - lock bit 1 protects, 0 leaves writable
// - only output and fault control protected
// - next access after keys is protected write
// - one unlock grants at most one protected write
// - exchange bit swaps high and low pins
// - align bit applies override at period boundary
`default_nettype none
module pwm_io_write_lock (
  // clock, reset, enable
  input  wire logic                                  sys_clk,
  input  wire logic                                  srst,
  input  wire logic                                  clk_en,
  // nonvolatile configuration
  input  wire logic [15:0]                           oscillator_select_config_word,
  // avalon-mm slave
  input  wire logic [pwm_lock_pkg::ADDR_W-1:0]       address,
  input  wire logic                                  read,
  input  wire logic                                  write,
  input  wire logic [pwm_lock_pkg::DATA_W-1:0]       writedata,
  input  wire logic [3:0]                            byteenable,
  output logic      [pwm_lock_pkg::DATA_W-1:0]       readdata,
  output logic                                       waitrequest,
  // fault inputs, active high
  input  wire logic [pwm_lock_pkg::NUM_GEN-1:0]      fault_in,
  // pwm pins
  output logic      [pwm_lock_pkg::NUM_GEN-1:0]      high_side_pin,
  output logic      [pwm_lock_pkg::NUM_GEN-1:0]      low_side_pin
);
  localparam int unsigned N = pwm_lock_pkg::NUM_GEN;

  // register state
  logic                                       pwm_write_lock_cfg;
  pwm_lock_pkg::unlock_state_type             unlock_state;
  logic                                       reject_flag;
  logic                                       pwm_timebase_enable;
  logic [15:0]                                period;
  logic [15:0]                                count;
  logic [N-1:0][15:0]                         pwm_output_control;
  logic [N-1:0][15:0]                         pwm_fault_limit_control;
  logic [N-1:0][15:0]                         duty;
  logic [N-1:0][1:0]                          ovr_en_eff;
  logic [N-1:0][1:0]                          override_data_value;

  // bus decode
  wire        req          = read | write;
  wire        accept       = clk_en & req & ~waitrequest;
  wire        acc_wr       = accept & write;
  wire [15:0] wmask        = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [15:0] wdata        = writedata[15:0];
  wire [7:0]  gen_off      = address - pwm_lock_pkg::ADDR_GEN_BASE;
  wire [1:0]  gen_idx      = gen_off[pwm_lock_pkg::GEN_STRIDE_LSB +: pwm_lock_pkg::GEN_IDX_W];
  wire [1:0]  gen_field    = address[pwm_lock_pkg::FIELD_LSB +: 2];
  wire        gen_hit      = (address >= pwm_lock_pkg::ADDR_GEN_BASE) && ({30'h0, gen_idx} < N)
                             && (address[1:0] == 2'h0)
                             && (gen_off[7:pwm_lock_pkg::GEN_STRIDE_LSB+pwm_lock_pkg::GEN_IDX_W] == '0);
  wire        hit_key      = address == pwm_lock_pkg::ADDR_UNLOCK_KEY;
  wire        hit_status   = address == pwm_lock_pkg::ADDR_STATUS;
  wire        hit_tb_ctrl  = address == pwm_lock_pkg::ADDR_TB_CTRL;
  wire        hit_period   = address == pwm_lock_pkg::ADDR_TB_PERIOD;
  wire        hit_oc       = gen_hit && gen_field == pwm_lock_pkg::FIELD_OUT_CTRL;
  wire        hit_fc       = gen_hit && gen_field == pwm_lock_pkg::FIELD_FAULT_CTRL;
  wire        hit_duty     = gen_hit && gen_field == pwm_lock_pkg::FIELD_DUTY;
  wire        hit_prot     = hit_oc | hit_fc;
  wire        key1_write   = acc_wr & hit_key & (wdata == pwm_lock_pkg::KEY_FIRST);
  wire        key2_write   = acc_wr & hit_key & (wdata == pwm_lock_pkg::KEY_SECOND);
  wire        prot_open    = ~pwm_write_lock_cfg | (unlock_state == pwm_lock_pkg::st_unlocked);
  wire        prot_wr_ok   = acc_wr & hit_prot & prot_open;
  wire        prot_wr_bad  = acc_wr & hit_prot & ~prot_open;
  wire        boundary     = pwm_timebase_enable & (count == period);

  pwm_lock_pkg::unlock_state_type next_unlock_state;
  always_comb begin
    next_unlock_state = unlock_state;
    if (accept) begin
      case (unlock_state)
        pwm_lock_pkg::st_idle:     next_unlock_state = key1_write ? pwm_lock_pkg::st_key1 : pwm_lock_pkg::st_idle;
        pwm_lock_pkg::st_key1:     next_unlock_state = key2_write ? pwm_lock_pkg::st_unlocked
                                                     : key1_write ? pwm_lock_pkg::st_key1 : pwm_lock_pkg::st_idle;
        pwm_lock_pkg::st_unlocked: next_unlock_state = key1_write ? pwm_lock_pkg::st_key1 : pwm_lock_pkg::st_idle;
        default:                   next_unlock_state = pwm_lock_pkg::st_idle;
      endcase
    end
  end

  // read mux
  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = pwm_lock_pkg::READ_ZERO;
    if (hit_status) begin
      next_readdata[pwm_lock_pkg::ST_LOCK_BIT]     = pwm_write_lock_cfg;
      next_readdata[pwm_lock_pkg::ST_KEY1_BIT]     = unlock_state == pwm_lock_pkg::st_key1;
      next_readdata[pwm_lock_pkg::ST_UNLOCKED_BIT] = unlock_state == pwm_lock_pkg::st_unlocked;
      next_readdata[pwm_lock_pkg::ST_REJECT_BIT]   = reject_flag;
    end else if (hit_tb_ctrl) begin
      next_readdata[pwm_lock_pkg::TB_ENABLE_BIT]   = pwm_timebase_enable;
    end else if (hit_period) begin
      next_readdata[15:0] = period;
    end else if (hit_oc) begin
      next_readdata[15:0] = pwm_output_control[gen_idx];
    end else if (hit_fc) begin
      next_readdata[15:0] = pwm_fault_limit_control[gen_idx];
    end else if (hit_duty) begin
      next_readdata[15:0] = duty[gen_idx];
    end
  end

  // one wait state per access; the key register reads as zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
      readdata    <= pwm_lock_pkg::READ_ZERO;
    end else if (clk_en) begin
      waitrequest <= ~(req & waitrequest);
      if (req & waitrequest) begin
        readdata <= read ? next_readdata : pwm_lock_pkg::READ_ZERO;
      end
    end
  end

  // lock bit caught while reset is held
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwm_write_lock_cfg <= oscillator_select_config_word[pwm_lock_pkg::LOCK_CFG_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      unlock_state <= pwm_lock_pkg::st_idle;
      reject_flag  <= 1'b0;
    end else if (clk_en) begin
      unlock_state <= next_unlock_state;
      // sticky until the next good protected write or a status read
      if (prot_wr_bad) begin
        reject_flag <= 1'b1;
      end else if (prot_wr_ok || (accept && read && hit_status)) begin
        reject_flag <= 1'b0;
      end
    end
  end

  // time base, never locked
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwm_timebase_enable <= 1'b0;
      period              <= pwm_lock_pkg::PERIOD_RESET;
      count               <= pwm_lock_pkg::COUNT_RESET;
    end else if (clk_en) begin
      if (acc_wr && hit_tb_ctrl && byteenable[0]) begin
        pwm_timebase_enable <= writedata[pwm_lock_pkg::TB_ENABLE_BIT];
      end
      if (acc_wr && hit_period) begin
        period <= (period & ~wmask) | (wdata & wmask);
      end
      if (!pwm_timebase_enable || boundary) begin
        count <= pwm_lock_pkg::COUNT_RESET;
      end else begin
        count <= count + pwm_lock_pkg::COUNT_STEP;
      end
    end
  end

  // per generator registers and pins
  for (genvar g = 0; g < N; g++) begin : gen_ch
    wire        sel      = {30'h0, gen_idx} == g;
    wire [15:0] oc       = pwm_output_control[g];
    wire        duty_h   = pwm_timebase_enable & (count < duty[g]);
    wire        duty_l   = pwm_timebase_enable & ~duty_h;
    wire        drv_h    = ovr_en_eff[g][1] ? override_data_value[g][1] : duty_h;
    wire        drv_l    = ovr_en_eff[g][0] ? override_data_value[g][0] : duty_l;
    wire        swap     = oc[pwm_lock_pkg::OC_EXCHANGE_BIT];
    wire        faulted  = pwm_fault_limit_control[g][pwm_lock_pkg::FC_FAULT_EN_BIT] & fault_in[g];
    wire        ovr_load = ~oc[pwm_lock_pkg::OC_ALIGN_BIT] | boundary;

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        pwm_output_control[g]      <= pwm_lock_pkg::OUT_CTRL_RESET;
        pwm_fault_limit_control[g] <= pwm_lock_pkg::FAULT_CTRL_RESET;
        duty[g]                    <= pwm_lock_pkg::DUTY_RESET;
        ovr_en_eff[g]              <= 2'h0;
        override_data_value[g]     <= 2'h0;
        high_side_pin[g]           <= 1'b0;
        low_side_pin[g]            <= 1'b0;
      end else if (clk_en) begin
        if (prot_wr_ok && hit_oc && sel) begin
          pwm_output_control[g] <= (oc & ~wmask) | (wdata & wmask);
        end
        if (prot_wr_ok && hit_fc && sel) begin
          pwm_fault_limit_control[g] <= (pwm_fault_limit_control[g] & ~wmask) | (wdata & wmask);
        end
        if (acc_wr && hit_duty && sel) begin
          duty[g] <= (duty[g] & ~wmask) | (wdata & wmask);
        end
        if (ovr_load) begin
          ovr_en_eff[g]          <= oc[pwm_lock_pkg::OC_OVR_EN_LSB +: 2];
          override_data_value[g] <= oc[pwm_lock_pkg::OC_OVR_DAT_LSB +: 2];
        end
        // fault forces both pins low, ahead of overrides
        high_side_pin[g] <= ~faulted & (swap ? drv_l : drv_h);
        low_side_pin[g]  <= ~faulted & (swap ? drv_h : drv_l);
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  wire [15:0] oc0 = pwm_output_control[0];

  lock_capture_a: assert property ($fell(srst) |->
    pwm_write_lock_cfg == $past(oscillator_select_config_word[pwm_lock_pkg::LOCK_CFG_BIT]))
    else $error("lock bit not taken from config word");

  free_write_a: assert property (!pwm_write_lock_cfg && acc_wr && hit_oc && byteenable[1:0] == 2'h3 |=>
    pwm_output_control[$past(gen_idx)] == $past(wdata))
    else $error("unlocked-config write to output control lost");

  locked_ignore_a: assert property (prot_wr_bad |=>
    $stable(pwm_output_control) && $stable(pwm_fault_limit_control) && reject_flag)
    else $error("protected register changed without unlock");

  scope_free_a: assert property (acc_wr && hit_duty && byteenable[1:0] == 2'h3 |=>
    duty[$past(gen_idx)] == $past(wdata))
    else $error("unprotected register write blocked");

  key_grant_a: assert property (unlock_state == pwm_lock_pkg::st_key1 && key2_write |=>
    unlock_state == pwm_lock_pkg::st_unlocked)
    else $error("key pair did not unlock");

  one_shot_a: assert property (unlock_state == pwm_lock_pkg::st_unlocked && accept |=>
    unlock_state != pwm_lock_pkg::st_unlocked)
    else $error("unlock outlived one access");

  seq_abort_a: assert property (unlock_state == pwm_lock_pkg::st_key1 && accept && !key2_write |=>
    unlock_state != pwm_lock_pkg::st_unlocked)
    else $error("broken key sequence still unlocked");

  bus_answer_a: assert property (clk_en && req && waitrequest |=> !waitrequest)
    else $error("access not answered in one cycle");

  swap_pin_a: assert property (clk_en && oc0[pwm_lock_pkg::OC_EXCHANGE_BIT] && !fault_in[0]
    && ovr_en_eff[0] == 2'h3 |=>
    high_side_pin[0] == $past(override_data_value[0][0]) && low_side_pin[0] == $past(override_data_value[0][1]))
    else $error("exchange did not cross the pins");

  ovr_hold_a: assert property (clk_en && oc0[pwm_lock_pkg::OC_ALIGN_BIT] && !boundary |=>
    $stable(ovr_en_eff[0]) && $stable(override_data_value[0]))
    else $error("aligned override applied off boundary");

  ovr_now_a: assert property (clk_en && !oc0[pwm_lock_pkg::OC_ALIGN_BIT] |=>
    ovr_en_eff[0] == $past(oc0[pwm_lock_pkg::OC_OVR_EN_LSB +: 2]))
    else $error("unaligned override not applied next clock");
endmodule
`default_nettype wire

// ==== design/pwm_lock_pkg.sv ====
// constants for the pwm write-protection gate and its register map
`default_nettype none
package pwm_lock_pkg;
  localparam int unsigned   NUM_GEN          = 3;
  localparam int unsigned   ADDR_W           = 8;
  localparam int unsigned   DATA_W           = 32;
  localparam int unsigned   REG_W            = 16;
  // register byte addresses
  localparam logic [7:0]    ADDR_UNLOCK_KEY  = 8'h00;
  localparam logic [7:0]    ADDR_STATUS      = 8'h04;
  localparam logic [7:0]    ADDR_TB_CTRL     = 8'h08;
  localparam logic [7:0]    ADDR_TB_PERIOD   = 8'h0C;
  localparam logic [7:0]    ADDR_GEN_BASE    = 8'h10;
  localparam int unsigned   GEN_STRIDE_LSB   = 4;
  localparam int unsigned   GEN_IDX_W        = 2;
  localparam int unsigned   FIELD_LSB        = 2;
  localparam logic [1:0]    FIELD_OUT_CTRL   = 2'h0;
  localparam logic [1:0]    FIELD_FAULT_CTRL = 2'h1;
  localparam logic [1:0]    FIELD_DUTY       = 2'h2;
  // unlock keys
  localparam logic [15:0]   KEY_FIRST        = 16'hABCD;
  localparam logic [15:0]   KEY_SECOND       = 16'h4321;
  // lock bit inside the oscillator select configuration word
  localparam int unsigned   LOCK_CFG_BIT     = 6;
  // output, fault and time-base control fields
  localparam int unsigned   OC_ALIGN_BIT     = 0;
  localparam int unsigned   OC_EXCHANGE_BIT  = 1;
  localparam int unsigned   OC_OVR_DAT_LSB   = 2;
  localparam int unsigned   OC_OVR_EN_LSB    = 4;
  localparam int unsigned   FC_FAULT_EN_BIT  = 0;
  localparam int unsigned   TB_ENABLE_BIT    = 0;
  // status fields
  localparam int unsigned   ST_LOCK_BIT      = 0;
  localparam int unsigned   ST_KEY1_BIT      = 1;
  localparam int unsigned   ST_UNLOCKED_BIT  = 2;
  localparam int unsigned   ST_REJECT_BIT    = 3;
  // reset values
  localparam logic [15:0]   OUT_CTRL_RESET   = 16'h0000;
  localparam logic [15:0]   FAULT_CTRL_RESET = 16'h0000;
  localparam logic [15:0]   DUTY_RESET       = 16'h0000;
  localparam logic [15:0]   PERIOD_RESET     = 16'hFFFF;
  localparam logic [15:0]   COUNT_RESET      = 16'h0000;
  localparam logic [15:0]   COUNT_STEP       = 16'h0001;
  localparam logic [31:0]   READ_ZERO        = 32'h0000_0000;
  typedef enum logic [1:0] {st_idle, st_key1, st_unlocked} unlock_state_type;
endpackage
`default_nettype wire

// ==== tb/pwm_io_write_lock_bench.sv ====
// self-checking bench for the pwm write-lock block
`default_nettype none
module pwm_io_write_lock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OC0   = 8'h10;
  localparam logic [7:0] FC0   = 8'h14;
  localparam logic [7:0] DUTY1 = 8'h28;
  localparam logic [7:0] KEY   = pwm_lock_pkg::ADDR_UNLOCK_KEY;
  localparam logic [7:0] STAT  = pwm_lock_pkg::ADDR_STATUS;
  logic        sys_clk;
  logic        srst;
  logic        clk_en;
  logic [15:0] cfg_word;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  fault_in;
  logic [2:0]  high_side_pin;
  logic [2:0]  low_side_pin;
  int          err_total;
  int          comparisons;
  int          cycles;

  pwm_io_write_lock DUT (
    .sys_clk                       (sys_clk),
    .srst                          (srst),
    .clk_en                        (clk_en),
    .oscillator_select_config_word (cfg_word),
    .address                       (address),
    .read                          (read),
    .write                         (write),
    .writedata                     (writedata),
    .byteenable                    (4'hF),
    .readdata                      (readdata),
    .waitrequest                   (waitrequest),
    .fault_in                      (fault_in),
    .high_side_pin                 (high_side_pin),
    .low_side_pin                  (low_side_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one avalon access; an edge always passes first so strobes never toggle twice in a step
  // no local limit: only the hang guard ends a wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp, "register read");
  endtask

  task automatic keys();
    wr(KEY, {16'h0000, pwm_lock_pkg::KEY_FIRST});
    wr(KEY, {16'h0000, pwm_lock_pkg::KEY_SECOND});
  endtask

  task automatic prot(input logic [7:0] a, input logic [31:0] d);
    keys();
    wr(a, d);
  endtask

  // pins are registered, so give them a few edges to settle
  task automatic pins(input logic hi, input logic lo);
    repeat (3) @(posedge sys_clk);
    check({30'h0, high_side_pin[0], low_side_pin[0]}, {30'h0, hi, lo}, "pin levels");
  endtask

  task automatic do_reset(input logic [15:0] cfg);
    @(posedge sys_clk);
    srst     <= 1'b1;
    cfg_word <= cfg;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
  endtask

  task automatic t_reset_vals();
    rd(OC0, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(FC0, 32'h0000_0000);
    rd(8'h0C, 32'h0000_FFFF);
    rd(8'hFC, 32'h0000_0000);
    rd(KEY, 32'h0000_0000);
    rd(STAT, 32'h0000_0001);
  endtask

  task automatic t_locked_ignore();
    wr(OC0, 32'h0000_0002);
    rd(OC0, 32'h0000_0000);
    rd(STAT, 32'h0000_0009);
    rd(STAT, 32'h0000_0001);
  endtask

  task automatic t_one_shot();
    prot(OC0, 32'h0000_0002);
    rd(OC0, 32'h0000_0002);
    wr(OC0, 32'h0000_0000);
    rd(OC0, 32'h0000_0002);
    prot(FC0, 32'h0000_0001);
    rd(FC0, 32'h0000_0001);
  endtask

  task automatic t_broken();
    rd(STAT, 32'h0000_0001);
    wr(KEY, {16'h0000, pwm_lock_pkg::KEY_FIRST});
    rd(STAT, 32'h0000_0003);
    wr(KEY, {16'h0000, pwm_lock_pkg::KEY_SECOND});
    wr(OC0, 32'h0000_0000);
    rd(OC0, 32'h0000_0002);
    wr(KEY, {16'h0000, pwm_lock_pkg::KEY_FIRST});
    wr(KEY, 32'h0000_4320);
    wr(KEY, {16'h0000, pwm_lock_pkg::KEY_SECOND});
    wr(OC0, 32'h0000_0000);
    rd(OC0, 32'h0000_0002);
    keys();
    rd(FC0, 32'h0000_0001);
    wr(OC0, 32'h0000_0000);
    rd(OC0, 32'h0000_0002);
  endtask

  task automatic t_unprot();
    wr(DUTY1, 32'h0000_0005);
    rd(DUTY1, 32'h0000_0005);
    wr(8'h08, 32'h0000_0001);
    rd(8'h08, 32'h0000_0001);
  endtask

  // clk_en low stalls the answer, the write still lands later
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en    <= 1'b0;
    address   <= DUTY1;
    writedata <= 32'h0000_0009;
    write     <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check({31'h0, waitrequest}, 32'h0000_0001, "frozen bus answered");
    clk_en <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    write <= 1'b0;
    rd(DUTY1, 32'h0000_0009);
  endtask

  task automatic oc_set(input logic [31:0] d);
    wr(8'h08, 32'h0000_0000);
    prot(OC0, d);
    wr(8'h08, 32'h0000_0001);
  endtask

  // gen0 duty is 0, so high side idles low and low side high
  task automatic t_pins();
    pins(1'b1, 1'b0);
    oc_set(32'h0000_0000);
    pins(1'b0, 1'b1);
    oc_set(32'h0000_0039);
    pins(1'b0, 1'b1);
    // short period so the aligned override reaches a boundary
    wr(8'h0C, 32'h0000_0040);
    repeat (80) @(posedge sys_clk);
    pins(1'b1, 1'b0);
    oc_set(32'h0000_003A);
    pins(1'b0, 1'b1);
    oc_set(32'h0000_0002);
    pins(1'b1, 1'b0);
    oc_set(32'h0000_0034);
    pins(1'b0, 1'b1);
    @(posedge sys_clk);
    fault_in <= 3'h1;
    pins(1'b0, 1'b0);
    fault_in <= 3'h0;
  endtask

  task automatic t_open();
    rd(STAT, 32'h0000_0000);
    wr(OC0, 32'h0000_0002);
    rd(OC0, 32'h0000_0002);
    wr(FC0, 32'h0000_0001);
    rd(FC0, 32'h0000_0001);
    rd(STAT, 32'h0000_0000);
  endtask

  initial begin
    srst        = 1'b1;
    clk_en      = 1'b1;
    cfg_word    = 16'h0040;
    address     = 8'h00;
    read        = 1'b0;
    write       = 1'b0;
    writedata   = 32'h0000_0000;
    fault_in    = 3'h0;
    err_total   = 0;
    comparisons = 0;
    cycles      = 0;
    do_reset(16'h0040);
    t_reset_vals();
    t_locked_ignore();
    t_one_shot();
    t_broken();
    t_unprot();
    t_freeze();
    t_pins();
    // second reset with only the lock bit cleared
    do_reset(16'hFFBF);
    t_open();
    results();
  end
endmodule
`default_nettype wire
